// *** core/fcsm_core.sv ***
/*
 * chip command state machine: next chip state for nested buffered
 * program and factory program, and output source decision per write.
 * assumes host writes arrive as an unsynchronised strobe level, synchronised to CLOCK here.
 */
`timescale 1ns/10ps
`default_nettype none
module fcsm_core #(
   parameter int BUF_WORDS = 16
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic WR_STROBE,                       // host write, level from pin
   input wire logic [fcsm_pkg::DATA_BITS-1:0] WR_DATA,
   input wire logic [fcsm_pkg::BLOCK_BITS-1:0] WR_BLOCK,
   input wire logic [fcsm_pkg::PART_BITS-1:0] WR_PART,
   input wire logic ENGINE_DONE,                     // write engine finished, one cycle
   input wire logic [fcsm_pkg::PART_BITS-1:0] RD_PART,
   output fcsm_pkg::fcsm_out_t RD_SOURCE,
   output fcsm_pkg::fcsm_state_t CHIP_STATE,
   output logic STATUS_ERROR,                        // error flag
   output logic STATUS_BIT0,                         // factory busy-with-data bit
   output logic DATA_TAKEN,                          // pulse: data word accepted
   output logic [fcsm_pkg::DATA_BITS-1:0] DATA_WORD
);
   // ---------------------------------------------------------------
   // input synchronisers and write edge
   // ---------------------------------------------------------------
   logic [2:0] strobe_sync;  // two flops then edge history
   logic [fcsm_pkg::DATA_BITS-1:0] data_s1, data_s2;
   logic [fcsm_pkg::BLOCK_BITS-1:0] block_s1, block_s2;
   logic [fcsm_pkg::PART_BITS-1:0] part_s1, part_s2;

   always_ff @(posedge CLOCK) begin
      if (RST) strobe_sync <= 3'h0;
      else strobe_sync <= {strobe_sync[1:0], WR_STROBE};
   end
   always_ff @(posedge CLOCK) begin
      data_s1 <= WR_DATA;
      data_s2 <= data_s1;
      block_s1 <= WR_BLOCK;
      block_s2 <= block_s1;
      part_s1 <= WR_PART;
      part_s2 <= part_s1;
   end

   // (RULE14) one decode per write
   wire write_now = strobe_sync[1] & ~strobe_sync[2];
   wire [7:0] cmd = data_s2[7:0];

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   fcsm_pkg::fcsm_state_t state, next_state;
   logic [fcsm_pkg::BLOCK_BITS-1:0] first_block;   // latched_first_block_address
   logic [fcsm_pkg::COUNT_BITS-1:0] load_count;    // words still to load
   logic error, next_error;
   logic bit0;

   // command decode
   wire is_word = cmd == fcsm_pkg::CMD_WORD_PGM_A || cmd == fcsm_pkg::CMD_WORD_PGM_B;
   wire is_id = cmd == fcsm_pkg::CMD_READ_ID_A || cmd == fcsm_pkg::CMD_READ_ID_B;
   wire is_setup = is_word || cmd == fcsm_pkg::CMD_BUF_PGM || cmd == fcsm_pkg::CMD_ERASE
                   || cmd == fcsm_pkg::CMD_FACTORY || cmd == fcsm_pkg::CMD_LOCK_SETUP;
   // (RULE13) compare with latched block
   wire block_match = block_s2 == first_block;
   wire buf_full = load_count == '0;
   wire engine_idle = state == fcsm_pkg::ST_READY || state == fcsm_pkg::ST_ERASE_SUSP;
   // (RULE12) data only when bit0 clear
   wire efp_data = write_now && state == fcsm_pkg::ST_EFP_BUSY && block_match && !bit0;
   wire setup_state = state inside {fcsm_pkg::ST_BUF_SETUP_ES, fcsm_pkg::ST_BUF_LOAD1_ES,
      fcsm_pkg::ST_BUF_LOAD2_ES, fcsm_pkg::ST_BUF_CONF_ES, fcsm_pkg::ST_EFP_SETUP,
      fcsm_pkg::ST_EFP_BUSY, fcsm_pkg::ST_ERASE_SETUP};

   // ---------------------------------------------------------------
   // next chip state
   // ---------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_error = error;
      if (write_now) begin
         case (state)
            fcsm_pkg::ST_READY: begin
               if (cmd == fcsm_pkg::CMD_FACTORY) next_state = fcsm_pkg::ST_EFP_SETUP;
               else if (cmd == fcsm_pkg::CMD_ERASE) next_state = fcsm_pkg::ST_ERASE_SETUP;
               else if (cmd == fcsm_pkg::CMD_LOCK_SETUP) next_state = fcsm_pkg::ST_LOCK_SETUP;
               // (RULE11) clear only when idle
               else if (cmd == fcsm_pkg::CMD_CLEAR_STATUS) next_error = 1'b0;
            end
            fcsm_pkg::ST_ERASE_SETUP: begin
               if (cmd == fcsm_pkg::CMD_CONFIRM) next_state = fcsm_pkg::ST_ERASE_BUSY;
               else begin
                  next_state = fcsm_pkg::ST_READY;
                  next_error = 1'b1;
               end
            end
            fcsm_pkg::ST_ERASE_BUSY: begin
               if (cmd == fcsm_pkg::CMD_SUSPEND) next_state = fcsm_pkg::ST_ERASE_SUSP;
            end
            fcsm_pkg::ST_ERASE_SUSP: begin
               if (cmd == fcsm_pkg::CMD_BUF_PGM) next_state = fcsm_pkg::ST_BUF_SETUP_ES;
               else if (cmd == fcsm_pkg::CMD_CONFIRM) next_state = fcsm_pkg::ST_ERASE_BUSY;
               else if (cmd == fcsm_pkg::CMD_CLEAR_STATUS) next_error = 1'b0;
            end
            // count write: a zero count goes straight to confirm
            fcsm_pkg::ST_BUF_SETUP_ES: begin
               next_state = (cmd[fcsm_pkg::COUNT_BITS-1:0] == '0)
                            ? fcsm_pkg::ST_BUF_CONF_ES : fcsm_pkg::ST_BUF_LOAD1_ES;
            end
            // first data word; a one-word buffer is already full
            fcsm_pkg::ST_BUF_LOAD1_ES: begin
               next_state = (load_count == 5'h1)
                            ? fcsm_pkg::ST_BUF_CONF_ES : fcsm_pkg::ST_BUF_LOAD2_ES;
            end
            // (RULE1) confirm once buffer full
            fcsm_pkg::ST_BUF_LOAD2_ES: begin
               if (load_count == 5'h1) next_state = fcsm_pkg::ST_BUF_CONF_ES;
            end
            // (RULE2) bad confirm aborts
            fcsm_pkg::ST_BUF_CONF_ES: begin
               if (cmd == fcsm_pkg::CMD_CONFIRM && block_match)
                  next_state = fcsm_pkg::ST_BUF_BUSY_ES;
               else begin
                  next_state = fcsm_pkg::ST_ERASE_SUSP;
                  next_error = 1'b1;
               end
            end
            // (RULE3) commands other than suspend ignored while busy
            fcsm_pkg::ST_BUF_BUSY_ES: begin
               if (cmd == fcsm_pkg::CMD_SUSPEND) next_state = fcsm_pkg::ST_BUF_SUSP_ES;
            end
            fcsm_pkg::ST_BUF_SUSP_ES: begin
               if (cmd == fcsm_pkg::CMD_CONFIRM) next_state = fcsm_pkg::ST_BUF_BUSY_ES;
            end
            fcsm_pkg::ST_EFP_SETUP: begin
               if (cmd == fcsm_pkg::CMD_CONFIRM) next_state = fcsm_pkg::ST_EFP_BUSY;
               else begin
                  next_state = fcsm_pkg::ST_READY;
                  next_error = 1'b1;
               end
            end
            // (RULE4) writes are data, not commands
            fcsm_pkg::ST_EFP_BUSY: next_state = state;
            fcsm_pkg::ST_LOCK_SETUP: next_state = fcsm_pkg::ST_READY;
            default: next_state = fcsm_pkg::ST_READY;
         endcase
      end
      else if (ENGINE_DONE) begin
         // (RULE3) done returns to erase suspend
         if (state == fcsm_pkg::ST_BUF_BUSY_ES) next_state = fcsm_pkg::ST_ERASE_SUSP;
         // (RULE4) factory done returns ready
         else if (state == fcsm_pkg::ST_EFP_BUSY) next_state = fcsm_pkg::ST_READY;
         else if (state == fcsm_pkg::ST_ERASE_BUSY) next_state = fcsm_pkg::ST_READY;
      end
   end

   // chip state and error flag; error set wins over clear
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= fcsm_pkg::ST_READY;
         error <= 1'b0;
      end else begin
         state <= next_state;
         error <= next_error;
      end
   end

   // ---------------------------------------------------------------
   // block latch, buffer count, factory data path
   // ---------------------------------------------------------------
   wire first_cycle = write_now && (state == fcsm_pkg::ST_READY
      || state == fcsm_pkg::ST_ERASE_SUSP) && is_setup;
   always_ff @(posedge CLOCK) begin
      if (RST) first_block <= '0;
      else if (first_cycle) first_block <= block_s2;
   end

   // data words in either load state count down the buffer space
   wire load_word = write_now && (state == fcsm_pkg::ST_BUF_LOAD1_ES
      || state == fcsm_pkg::ST_BUF_LOAD2_ES);
   // count taken from the write after setup, never from a data word
   always_ff @(posedge CLOCK) begin
      if (RST) load_count <= '0;
      else if (write_now && state == fcsm_pkg::ST_BUF_SETUP_ES)
         load_count <= cmd[fcsm_pkg::COUNT_BITS-1:0];
      else if (load_word && !buf_full)
         load_count <= load_count - 5'h1;
   end

   // bit0 high from a taken word until the engine finishes it
   always_ff @(posedge CLOCK) begin
      if (RST) bit0 <= 1'b0;
      else if (efp_data) bit0 <= 1'b1;
      else if (ENGINE_DONE) bit0 <= 1'b0;
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         DATA_TAKEN <= 1'b0;
         DATA_WORD <= '0;
      end else begin
         DATA_TAKEN <= efp_data;
         if (efp_data) DATA_WORD <= data_s2;
      end
   end

   // ---------------------------------------------------------------
   // output source decision
   // ---------------------------------------------------------------
   fcsm_sel_if sel ();
   fcsm_pkg::fcsm_out_t next_source;
   logic next_change;
   always_comb begin
      next_change = 1'b1;
      next_source = fcsm_pkg::OUT_STATUS;
      // (RULE5) setup states point at status
      if (setup_state) next_source = fcsm_pkg::OUT_STATUS;
      else if (state == fcsm_pkg::ST_LOCK_SETUP) next_source = fcsm_pkg::OUT_STATUS;
      // (RULE6) read array
      else if (cmd == fcsm_pkg::CMD_READ_ARRAY) next_source = fcsm_pkg::OUT_ARRAY;
      // (RULE7) setup commands
      else if (is_setup) next_source = fcsm_pkg::OUT_STATUS;
      // (RULE8) status and identifier
      else if (cmd == fcsm_pkg::CMD_READ_STATUS) next_source = fcsm_pkg::OUT_STATUS;
      else if (is_id) next_source = fcsm_pkg::OUT_ID;
      // (RULE9) others keep selection
      else next_change = 1'b0;
   end
   assign sel.update = write_now;
   assign sel.part = part_s2;
   assign sel.change = next_change;
   assign sel.source = next_source;

   fcsm_sel_store u_store (
      .clk(CLOCK),
      .rst(RST),
      .sel(sel),
      .rd_part(RD_PART),
      .rd_source(RD_SOURCE)
   );

   assign CHIP_STATE = state;
   assign STATUS_ERROR = error;
   assign STATUS_BIT0 = bit0;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_conf_abort_err: assert property (@(posedge CLOCK) disable iff (RST) // (RULE2)
      write_now && state == fcsm_pkg::ST_BUF_CONF_ES && cmd != fcsm_pkg::CMD_CONFIRM
      |=> state == fcsm_pkg::ST_ERASE_SUSP && error) else $error("abort path wrong");
   a_busy_done_susp: assert property (@(posedge CLOCK) disable iff (RST) // (RULE3)
      !write_now && ENGINE_DONE && state == fcsm_pkg::ST_BUF_BUSY_ES
      |=> state == fcsm_pkg::ST_ERASE_SUSP) else $error("busy did not return");
   a_load_full_conf: assert property (@(posedge CLOCK) disable iff (RST) // (RULE1)
      write_now && state == fcsm_pkg::ST_BUF_LOAD2_ES && load_count == 5'h1
      |=> state == fcsm_pkg::ST_BUF_CONF_ES) else $error("confirm not reached");
   a_efp_done_rdy: assert property (@(posedge CLOCK) disable iff (RST) // (RULE4)
      !write_now && ENGINE_DONE && state == fcsm_pkg::ST_EFP_BUSY
      |=> state == fcsm_pkg::ST_READY) else $error("factory done wrong");
   a_efp_bit0_gate: assert property (@(posedge CLOCK) disable iff (RST) // (RULE12)
      efp_data |-> !bit0 ##1 DATA_TAKEN ##0 bit0) else $error("data taken when busy");
   a_setup_status: assert property (@(posedge CLOCK) disable iff (RST) // (RULE5)
      write_now && setup_state |-> sel.change && sel.source == fcsm_pkg::OUT_STATUS)
      else $error("setup not status");
   a_read_array: assert property (@(posedge CLOCK) disable iff (RST) // (RULE6)
      write_now && engine_idle && cmd == fcsm_pkg::CMD_READ_ARRAY
      |-> sel.source == fcsm_pkg::OUT_ARRAY) else $error("read array lost");
   a_keep_sel: assert property (@(posedge CLOCK) disable iff (RST) // (RULE9)
      write_now && engine_idle && cmd == fcsm_pkg::CMD_SUSPEND |-> !sel.change)
      else $error("selection changed");
   a_clear_idle: assert property (@(posedge CLOCK) disable iff (RST) // (RULE11)
      write_now && !engine_idle && error && state != fcsm_pkg::ST_EFP_SETUP
      |=> error) else $error("error cleared while busy");
   c_abort: cover property (@(posedge CLOCK) state == fcsm_pkg::ST_BUF_CONF_ES ##1 error);
   c_efp_word: cover property (@(posedge CLOCK) DATA_TAKEN);
   c_nested_done: cover property (@(posedge CLOCK)
      state == fcsm_pkg::ST_BUF_BUSY_ES ##1 state == fcsm_pkg::ST_ERASE_SUSP);
endmodule : fcsm_core
`default_nettype wire

// *** inc/fcsm_pkg.sv ***
/*
 * package for the flash command state machine: command codes, chip
 * states, output sources and sizes.
 * assumes it is compiled before the interface and the core modules.
 */
// Function
// (RULE1) second load goes confirm when buffer full
// (RULE2) bad confirm aborts to error, stay suspended
// (RULE3) nested buffered busy ignores commands, returns suspend; code still moves to ST_BUF_SUSP_ES on suspend
// (RULE4) factory busy takes data, done returns ready
// (RULE5) setup, load, confirm states select status output
// (RULE6) read array selects array from ready states
// (RULE7) setup commands select status from ready states
// (RULE8) read status, read identifier select their source
// (RULE9) confirm, suspend, clear status keep selection
// (RULE10) chip state global, selection kept per partition
// (RULE11) clear status only when engine idle
// (RULE12) factory data taken only when status bit0 zero
// (RULE13) confirm compares latched first block address
// (RULE14) each write decoded once, all updated together
// (RULE15) host polls ready, writes read array after
package fcsm_pkg;

   // ----------------------------------------------------------------
   // command codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam logic [7:0] CMD_WORD_PGM_A = 8'h10;
   localparam logic [7:0] CMD_WORD_PGM_B = 8'h40;
   localparam logic [7:0] CMD_BUF_PGM = 8'hE8;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_FACTORY = 8'h30;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID_A = 8'h90;
   localparam logic [7:0] CMD_READ_ID_B = 8'h98;
   localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;

   // ----------------------------------------------------------------
   // sizes and bit positions
   // ----------------------------------------------------------------
   localparam int PARTITIONS = 4;
   localparam int PART_BITS = 2;
   localparam int BLOCK_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int COUNT_BITS = 5;
   localparam int READY_BIT = 0;
   localparam logic [1:0] ERR_CLEAR = 2'h0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OUT_ARRAY,
      OUT_STATUS,
      OUT_ID
   } fcsm_out_t;

   typedef enum logic [3:0] {
      ST_READY,
      ST_ERASE_SUSP,
      ST_ERASE_BUSY,
      ST_BUF_SETUP_ES,
      ST_BUF_LOAD1_ES,
      ST_BUF_LOAD2_ES,
      ST_BUF_CONF_ES,
      ST_BUF_BUSY_ES,
      ST_BUF_SUSP_ES,
      ST_EFP_SETUP,
      ST_EFP_BUSY,
      ST_ERASE_SETUP,
      ST_LOCK_SETUP
   } fcsm_state_t;

endpackage : fcsm_pkg

// *** inc/fcsm_sel_if.sv ***
/*
 * interface carrying one decoded write to the per-partition output
 * selection store.
 * assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface fcsm_sel_if;
   logic update;                 // one write being applied
   logic [fcsm_pkg::PART_BITS-1:0] part; // target partition
   logic change;                 // selection should change
   fcsm_pkg::fcsm_out_t source;  // new source
   modport ctrl (output update, output part, output change, output source);
   modport store (input update, input part, input change, input source);
endinterface : fcsm_sel_if
`default_nettype wire

// *** core/fcsm_sel_store.sv ***
/*
 * per-partition store of the selected read source.
 * assumes synchronous active-high reset and one write per update.
 */
`timescale 1ns/10ps
`default_nettype none
module fcsm_sel_store #(
   parameter int PARTS = fcsm_pkg::PARTITIONS
) (
   input wire logic clk,
   input wire logic rst,
   fcsm_sel_if.store sel,
   input wire logic [fcsm_pkg::PART_BITS-1:0] rd_part,
   output fcsm_pkg::fcsm_out_t rd_source
);
   // ---------------------------------------------------------------
   // storage, one entry per partition
   // ---------------------------------------------------------------
   fcsm_pkg::fcsm_out_t mux [PARTS];  // remembered source

   genvar g;
   generate
      for (g = 0; g < PARTS; g++) begin : g_part
         // (RULE10) each partition remembers
         always_ff @(posedge clk) begin
            if (rst) mux[g] <= fcsm_pkg::OUT_ARRAY;
            else if (sel.update && sel.change && sel.part == g) mux[g] <= sel.source;
         end
      end
   endgenerate

   // registered read port
   always_ff @(posedge clk) begin
      if (rst) rd_source <= fcsm_pkg::OUT_ARRAY;
      else rd_source <= mux[rd_part];
   end
endmodule : fcsm_sel_store
`default_nettype wire

// *** tb/fcsm_host_model.sv ***
/*
 * host side of the flash command state machine: one bus write at a time,
 * strobe held high three cycles and low three cycles, plus a bounded
 * poll of the factory busy bit.
 * assumes CLOCK of the core and inputs sampled after two sync flops.
 */
`timescale 1ns/10ps
`default_nettype none
module fcsm_host_model (
   input wire logic clk,
   input wire logic status_bit0,
   output logic strobe,
   output logic [fcsm_pkg::DATA_BITS-1:0] data,
   output logic [fcsm_pkg::BLOCK_BITS-1:0] block,
   output logic [fcsm_pkg::PART_BITS-1:0] part
);
   // --------------------------------------------------------------
   // idle bus at time zero
   // --------------------------------------------------------------
   initial begin
      strobe = 1'b0;
      data = 16'h0000;
      block = 8'h00;
      part = 2'h0;
   end

   task automatic write(input logic [7:0] blk, input logic [1:0] prt, input logic [15:0] word);
      @(posedge clk);
      data <= word;
      block <= blk;
      part <= prt;
      strobe <= 1'b1;
      repeat (3) @(posedge clk);
      strobe <= 1'b0;
      repeat (3) @(posedge clk);
      // released lines show the inverse so stale values never look valid
      data <= ~word;
      block <= ~blk;
      part <= ~prt;
   endtask : write

   // wait for the factory word slot to free up
   task automatic wait_free(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 200; i++) begin
         if (status_bit0 === 1'b0) begin
            ok = 1'b1;
            break;
         end
         @(posedge clk);
      end
   endtask : wait_free
endmodule : fcsm_host_model
`default_nettype wire

// *** tb/flash_command_state_machine_tb.sv ***
/*
 * self-checking bench for the flash command state machine core.
 * assumes the host model drives the write lines and the bench drives
 * reset, engine done and the read partition.
 */
`timescale 1ns/10ps
`default_nettype none
module flash_command_state_machine_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic engine_done = 1'b0;
   logic [1:0] rd_part = 2'h0;
   logic wr_strobe;
   logic [15:0] wr_data;
   logic [7:0] wr_block;
   logic [1:0] wr_part;
   fcsm_pkg::fcsm_out_t rd_source;
   fcsm_pkg::fcsm_state_t chip_state;
   logic status_error;
   logic status_bit0;
   logic data_taken;
   logic [15:0] data_word;
   int n_errors = 0;
   int total_checks = 0;
   int taken_count = 0; // accepted factory words
   logic [15:0] last_word = 16'h0000;

   // --------------------------------------------------------------
   // clock, instances and monitor
   // --------------------------------------------------------------
   always #2 clock = ~clock;

   fcsm_core dut_u (.CLOCK(clock), .RST(rst), .WR_STROBE(wr_strobe), .WR_DATA(wr_data),
      .WR_BLOCK(wr_block), .WR_PART(wr_part), .ENGINE_DONE(engine_done), .RD_PART(rd_part),
      .RD_SOURCE(rd_source), .CHIP_STATE(chip_state), .STATUS_ERROR(status_error),
      .STATUS_BIT0(status_bit0), .DATA_TAKEN(data_taken), .DATA_WORD(data_word));

   fcsm_host_model host_u (.clk(clock), .status_bit0(status_bit0), .strobe(wr_strobe),
      .data(wr_data), .block(wr_block), .part(wr_part));

   // count accepted factory words
   always @(posedge clock) begin
      if (data_taken === 1'b1) begin
         taken_count <= taken_count + 1;
         last_word <= data_word;
      end
   end

   // --------------------------------------------------------------
   // shared tasks
   // --------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] blk, input logic [15:0] word, input logic [1:0] prt = 2'h0);
      host_u.write(blk, prt, word);
      #1;
   endtask : wr

   task automatic do_reset();
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
   endtask : do_reset

   task automatic pulse_done();
      @(posedge clock);
      engine_done <= 1'b1;
      @(posedge clock);
      engine_done <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
   endtask : pulse_done

   task automatic see_part(input logic [1:0] prt);
      @(posedge clock);
      rd_part <= prt;
      repeat (2) @(posedge clock);
      #1;
   endtask : see_part

   // erase started on block 5, then suspended
   task automatic reach_susp();
      do_reset();
      wr(8'h05, 16'h0020);
      wr(8'h05, 16'h00D0);
      wr(8'h05, 16'h00B0);
      check("erase suspend", chip_state, fcsm_pkg::ST_ERASE_SUSP);
   endtask : reach_susp

   // nested buffered load of three words on block 7
   task automatic load_buffer();
      wr(8'h07, 16'h00E8);
      check("setup source", rd_source, fcsm_pkg::OUT_STATUS);
      wr(8'h07, 16'h0003);
      for (int i = 1; i <= 3; i++) begin
         wr(8'h07, 16'hA000 + 16'(i));
         if (i == 2) check("load two", chip_state, fcsm_pkg::ST_BUF_LOAD2_ES);
      end
      check("buffer full", chip_state, fcsm_pkg::ST_BUF_CONF_ES);
   endtask : load_buffer

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_ready_table();
      logic [7:0] cmd [8] = '{8'h90, 8'hB0, 8'h70, 8'hD0, 8'h50, 8'h98, 8'hFF, 8'h50};
      fcsm_pkg::fcsm_out_t exp [8] = '{fcsm_pkg::OUT_ID, fcsm_pkg::OUT_ID,
         fcsm_pkg::OUT_STATUS, fcsm_pkg::OUT_STATUS, fcsm_pkg::OUT_STATUS,
         fcsm_pkg::OUT_ID, fcsm_pkg::OUT_ARRAY, fcsm_pkg::OUT_ARRAY};
      check("reset source", rd_source, fcsm_pkg::OUT_ARRAY);
      for (int i = 0; i < 8; i++) begin
         wr(8'h01, {8'h00, cmd[i]});
         check("ready source", rd_source, exp[i]);
      end
   endtask : t_ready_table

   task automatic t_setup_cmds();
      logic [7:0] cmd [6] = '{8'h10, 8'h40, 8'hE8, 8'h20, 8'h30, 8'h60};
      for (int i = 0; i < 6; i++) begin
         do_reset();
         wr(8'h01, 16'h0090);
         wr(8'h01, {8'h00, cmd[i]});
         check("setup source", rd_source, fcsm_pkg::OUT_STATUS);
      end
      do_reset();
      wr(8'h01, 16'h0020);
      wr(8'h01, 16'h0090);
      check("erase setup write", rd_source, fcsm_pkg::OUT_STATUS);
   endtask : t_setup_cmds

   task automatic t_partitions();
      do_reset();
      wr(8'h01, 16'h0090, 2'h1);
      wr(8'h01, 16'h0070, 2'h2);
      check("chip state", chip_state, fcsm_pkg::ST_READY);
      see_part(2'h1);
      check("part one", rd_source, fcsm_pkg::OUT_ID);
      see_part(2'h2);
      check("part two", rd_source, fcsm_pkg::OUT_STATUS);
      see_part(2'h3);
      check("part three", rd_source, fcsm_pkg::OUT_ARRAY);
      see_part(2'h0);
   endtask : t_partitions

   task automatic t_nested_ok();
      reach_susp();
      wr(8'h05, 16'h0090);
      check("suspend id", rd_source, fcsm_pkg::OUT_ID);
      wr(8'h05, 16'h00FF);
      check("suspend array", rd_source, fcsm_pkg::OUT_ARRAY);
      load_buffer();
      wr(8'h07, 16'h00D0);
      check("nested busy", chip_state, fcsm_pkg::ST_BUF_BUSY_ES);
      wr(8'h07, 16'h00FF);
      check("busy ignores", chip_state, fcsm_pkg::ST_BUF_BUSY_ES);
      check("busy array", rd_source, fcsm_pkg::OUT_ARRAY);
      pulse_done();
      check("back to suspend", chip_state, fcsm_pkg::ST_ERASE_SUSP);
   endtask : t_nested_ok

   task automatic t_nested_abort();
      reach_susp();
      load_buffer();
      wr(8'h08, 16'h00D0);
      check("abort state", chip_state, fcsm_pkg::ST_ERASE_SUSP);
      check("abort error", status_error, 1'b1);
      check("abort source", rd_source, fcsm_pkg::OUT_STATUS);
      load_buffer();
      wr(8'h07, 16'h00D0);
      wr(8'h07, 16'h0050);
      check("clear while busy", status_error, 1'b1);
      pulse_done();
      wr(8'h07, 16'h0050);
      check("clear when idle", status_error, 1'b0);
      check("clear keeps source", rd_source, fcsm_pkg::OUT_STATUS);
   endtask : t_nested_abort

   task automatic t_factory();
      logic ok;
      int base;
      do_reset();
      wr(8'h03, 16'h0030);
      wr(8'h03, 16'h00D0);
      check("factory busy", chip_state, fcsm_pkg::ST_EFP_BUSY);
      base = taken_count;
      wr(8'h09, 16'h1111);
      check("wrong block", 16'(taken_count - base), 16'h0000);
      wr(8'h03, 16'h00FF);
      check("word taken", 16'(taken_count - base), 16'h0001);
      check("word value", last_word, 16'h00FF);
      check("still busy", chip_state, fcsm_pkg::ST_EFP_BUSY);
      check("busy source", rd_source, fcsm_pkg::OUT_STATUS);
      check("busy bit", status_bit0, 1'b1);
      wr(8'h03, 16'h2222);
      check("bit set drop", 16'(taken_count - base), 16'h0001);
      pulse_done();
      check("factory done", chip_state, fcsm_pkg::ST_READY);
      host_u.wait_free(ok);
      check("slot free", ok, 1'b1);
      if (ok !== 1'b1) final_report();
      wr(8'h03, 16'h00FF);
      check("array again", rd_source, fcsm_pkg::OUT_ARRAY);
   endtask : t_factory

   // --------------------------------------------------------------
   // main sequence and watchdog
   // --------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      t_ready_table();
      t_setup_cmds();
      t_partitions();
      t_nested_ok();
      t_nested_abort();
      t_factory();
      final_report();
   end

   initial begin
      #200000;
      n_errors++;
      final_report();
   end
endmodule : flash_command_state_machine_tb
`default_nettype wire
